// File: logic/exec_pkg.sv
// shared constants and types for the sleep and borrow-subtract executor
package exec_pkg;
    // instruction encodings
    localparam logic [15:0] SLEEP_OPCODE = 16'h0003;
    localparam logic [5:0] SUB_BORROW_TOP = 6'h15;
    localparam int OPC_TOP_HI = 15;
    localparam int OPC_TOP_LO = 10;
    localparam int DEST_BIT = 9;
    localparam int BANK_BIT = 8;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

    // apb register byte offsets
    localparam logic [7:0] STATUS_OFFS = 8'h00;
    localparam logic [7:0] WORK_OFFS = 8'h04;
    localparam logic [7:0] BANKSEL_OFFS = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFFS = 8'h0C;
    localparam logic [7:0] IRQ_MASK_OFFS = 8'h10;
    localparam logic [7:0] CORE_STATE_OFFS = 8'h14;

    // status register fields
    localparam int C_POS = 0;
    localparam int DIGC_POS = 1;
    localparam int Z_POS = 2;
    localparam int OVF_POS = 3;
    localparam int N_POS = 4;
    localparam int PWRDN_POS = 5;
    localparam int TMOUT_POS = 6;
    localparam int ALU_FLAGS = 5;

    // interrupt event bits
    localparam int EV_SLEEP = 0;
    localparam int EV_WAKE_DOG = 1;
    localparam int EV_WAKE_OTHER = 2;
    localparam int EV_SUB_DONE = 3;
    localparam int EV_COUNT = 4;

    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic [3:0] BANKSEL_RESET = 4'h0;

    // four-phase instruction cycle
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } phase_t;

    // data memory write request
    typedef struct packed {
        logic we;
        logic [11:0] addr;
        logic [7:0] data;
    } mem_wr_t;
endpackage

// File: logic/data_ram.sv
// banked data memory with registered read port
module data_ram #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    input wire logic pclk,
    input wire logic en,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // no reset on the array; contents are undefined until written
    always_ff @(posedge pclk) begin
        if (en) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end
endmodule // data_ram

// File: logic/sleep_sub_exec.sv
// executor for the sleep and reverse borrow-subtract instructions
//
// Functional notes
// - sleep clears the active-low powerdown flag.
// - sleep sets the active-low timeout flag.
// - sleep clears the watchdog counter and its postscaler.
// - after sleep the core stops, oscillator halted, until a wake-up.
// - a watchdog wake-up from stop clears the timeout flag.
// - subtract computes W minus file minus inverted carry, two's complement.
// - d=0 writes the result to W, d=1 writes it to the file register.
// - an omitted d operand means d=1, result to file register.
// - a=0 uses the access bank and ignores bank select.
// - a=1 takes the bank from the bank select register.
//
// The placing of the registers and the APB register port were chosen for this implementation.
module sleep_sub_exec
    import exec_pkg::*;
#(
    parameter int AW = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    output logic instr_ready,
    input wire logic wake_watchdog,
    input wire logic wake_other,
    output logic watchdog_clear,
    output logic postscaler_clear,
    output logic osc_stop,
    output logic irq
);
    phase_t phase_q;
    logic stopped_q;
    logic is_sleep_q, is_sub_q, dest_q;
    logic [AW-1:0] op_addr_q;
    logic [7:0] work_q, result_q, file_rdata;
    logic [3:0] banksel_q;
    logic [ALU_FLAGS-1:0] alu_q, alu_res_q;
    logic pwrdn_n_q, to_n_q;
    logic [EV_COUNT-1:0] irq_stat_q, irq_mask_q, ev;
    mem_wr_t mem_wr;
    logic acc, wr_en, rd_setup, mapped, is_sleep_d, is_sub_d, take;
    logic sleep_done, sub_done, wake_any;

    // bank address: access bank splits low/high, else bank select
    function automatic logic [AW-1:0] bank_addr(input logic a,
            input logic [7:0] f, input logic [3:0] bsel);
        logic [3:0] bank;
        bank = bsel;
        if (!a) begin
            bank = (f < ACCESS_SPLIT) ? ACCESS_LOW_BANK
                                      : ACCESS_HIGH_BANK;
        end
        return AW'({bank, f});
    endfunction

    // w - f - !c as w + ~f + c; returns {n, ov, z, dc, c, result}
    function automatic logic [12:0] sub_borrow(input logic [7:0] w,
            input logic [7:0] f, input logic c);
        logic [8:0] full;
        logic [4:0] low;
        logic [7:0] r;
        logic ov;
        full = {1'b0, w} + {1'b0, ~f} + {8'h00, c};
        low = {1'b0, w[3:0]} + {1'b0, ~f[3:0]} + {4'h0, c};
        r = full[7:0];
        ov = (w[7] != f[7]) && (r[7] != w[7]);
        return {r[7], ov, (r == 8'h00), low[4], full[8], r};
    endfunction

    // opcode decode
    assign is_sleep_d = (instr_word == SLEEP_OPCODE);
    assign is_sub_d =
        (instr_word[OPC_TOP_HI:OPC_TOP_LO] == SUB_BORROW_TOP);
    // new word taken only at Q1 of a running core
    assign instr_ready = clk_en && !stopped_q && phase_q == PH_Q1;
    assign take = instr_ready && instr_valid;
    assign sleep_done = clk_en && phase_q == PH_Q4 && is_sleep_q;
    assign sub_done = clk_en && phase_q == PH_Q4 && is_sub_q;
    assign wake_any = clk_en && stopped_q && (wake_watchdog || wake_other);

    // apb decode; pready waits on clk_en so frozen writes are not lost
    assign acc = psel && penable;
    assign pready = clk_en;
    assign mapped = paddr == STATUS_OFFS || paddr == WORK_OFFS ||
                    paddr == BANKSEL_OFFS || paddr == IRQ_STAT_OFFS ||
                    paddr == IRQ_MASK_OFFS || paddr == CORE_STATE_OFFS;
    assign pslverr = acc && !mapped;
    assign wr_en = clk_en && acc && pwrite && mapped;
    assign rd_setup = clk_en && psel && !penable && !pwrite;

    // phase counter; frozen while stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= PH_Q1;
        end else if (clk_en && !stopped_q) begin
            case (phase_q)
                PH_Q1: phase_q <= PH_Q2;
                PH_Q2: phase_q <= PH_Q3;
                PH_Q3: phase_q <= PH_Q4;
                PH_Q4: phase_q <= PH_Q1;
                default: phase_q <= PH_Q1;
            endcase
        end
    end

    // latch decoded instruction at Q1; unknown words run as no-ops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            is_sleep_q <= 1'b0;
            is_sub_q <= 1'b0;
            dest_q <= 1'b1;
            op_addr_q <= '0;
        end else if (clk_en && !stopped_q && phase_q == PH_Q1) begin
            is_sleep_q <= take && is_sleep_d;
            is_sub_q <= take && is_sub_d;
            // d=1 is also what an omitted operand assembles to
            dest_q <= instr_word[DEST_BIT];
            op_addr_q <= bank_addr(instr_word[BANK_BIT], instr_word[7:0],
                                   banksel_q);
        end
    end

    // operand arrives at Q3; compute result and flags there
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= 8'h00;
            alu_res_q <= '0;
        end else if (clk_en && phase_q == PH_Q3) begin
            {alu_res_q, result_q} <=
                sub_borrow(work_q, file_rdata, alu_q[C_POS]);
        end
    end

    // file write-back at Q4 when d=1
    always_comb begin
        mem_wr.we = sub_done && dest_q;
        mem_wr.addr = op_addr_q[11:0];
        mem_wr.data = result_q;
    end

    data_ram #(.AW(AW), .DW(8)) u_ram (
        .pclk(pclk),
        .en(clk_en),
        .raddr(op_addr_q),
        .rdata(file_rdata),
        .we(mem_wr.we),
        .waddr(mem_wr.addr),
        .wdata(mem_wr.data)
    );

    // working register: core write-back wins over software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            work_q <= WORK_RESET;
        end else if (sub_done && !dest_q) begin
            work_q <= result_q;
        end else if (wr_en && paddr == WORK_OFFS) begin
            work_q <= pwdata[7:0];
        end
    end

    // bank select, software owned
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            banksel_q <= BANKSEL_RESET;
        end else if (wr_en && paddr == BANKSEL_OFFS) begin
            banksel_q <= pwdata[3:0];
        end
    end

    // arithmetic flags: instruction update wins over software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alu_q <= '0;
        end else if (sub_done) begin
            alu_q <= alu_res_q;
        end else if (wr_en && paddr == STATUS_OFFS) begin
            alu_q <= pwdata[ALU_FLAGS-1:0];
        end
    end

    // power flags are read-only; both idle high after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwrdn_n_q <= 1'b1;
            to_n_q <= 1'b1;
        end else if (sleep_done) begin
            pwrdn_n_q <= 1'b0;
            to_n_q <= 1'b1;
        end else if (wake_any && wake_watchdog) begin
            to_n_q <= 1'b0;
        end
    end

    // stop state: entered at end of sleep, left on any wake-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stopped_q <= 1'b0;
        end else if (sleep_done) begin
            stopped_q <= 1'b1;
        end else if (wake_any) begin
            stopped_q <= 1'b0;
        end
    end
    assign osc_stop = stopped_q;

    // watchdog clear pulses, one cycle after the sleep completes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_clear <= 1'b0;
            postscaler_clear <= 1'b0;
        end else if (clk_en) begin
            watchdog_clear <= sleep_done;
            postscaler_clear <= sleep_done;
        end
    end

    // sticky events; a new event beats a simultaneous write-one clear
    assign ev = {sub_done, wake_any && !wake_watchdog,
                 wake_any && wake_watchdog,
                 sleep_done};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= '0;
        end else if (clk_en) begin
            if (wr_en && paddr == IRQ_STAT_OFFS) begin
                irq_stat_q <= (irq_stat_q & ~pwdata[EV_COUNT-1:0]) | ev;
            end else begin
                irq_stat_q <= irq_stat_q | ev;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= '0;
        end else if (wr_en && paddr == IRQ_MASK_OFFS) begin
            irq_mask_q <= pwdata[EV_COUNT-1:0];
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    // read data captured in setup so it stands through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (paddr)
                STATUS_OFFS: prdata <= 32'({to_n_q, pwrdn_n_q, alu_q});
                WORK_OFFS: prdata <= 32'(work_q);
                BANKSEL_OFFS: prdata <= 32'(banksel_q);
                IRQ_STAT_OFFS: prdata <= 32'(irq_stat_q);
                IRQ_MASK_OFFS: prdata <= 32'(irq_mask_q);
                CORE_STATE_OFFS: prdata <= 32'({stopped_q, phase_q});
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_SLEEP_PWRDN: assert property (sleep_done |=> !pwrdn_n_q)
        else $error("powerdown flag not cleared by sleep");
    AST_SLEEP_TO: assert property (sleep_done |=> to_n_q)
        else $error("timeout flag not set by sleep");
    AST_DOG_CLR: assert property (sleep_done |=>
            watchdog_clear && postscaler_clear)
        else $error("watchdog not cleared by sleep");
    // the phase wraps to Q1 on the sleep edge and must then sit there
    AST_STOP: assert property (sleep_done ##1
            (!wake_watchdog && !wake_other)
            |-> osc_stop && !instr_ready && phase_q == PH_Q1)
        else $error("core ran while stopped");
    AST_WAKE_DOG: assert property (wake_any && wake_watchdog
            |=> !to_n_q && !stopped_q)
        else $error("watchdog wake did not clear timeout flag");
    AST_SUB_VAL: assert property (clk_en && phase_q == PH_Q3
            |=> result_q == 8'($past(work_q) - $past(file_rdata)
                - {7'h00, !$past(alu_q[C_POS])}))
        else $error("subtract result wrong");
    AST_DEST_W: assert property (sub_done && !dest_q
            |=> work_q == $past(result_q))
        else $error("result not written to working register");
    AST_DEST_F: assert property (sub_done && dest_q |-> mem_wr.we)
        else $error("result not written to file register");
    AST_ACCESS: assert property (take && !instr_word[BANK_BIT]
            |=> op_addr_q[11:8] == ACCESS_LOW_BANK ||
                op_addr_q[11:8] == ACCESS_HIGH_BANK)
        else $error("access bank not used");
    AST_BANKSEL: assert property (take && instr_word[BANK_BIT]
            |=> op_addr_q[11:8] == $past(banksel_q))
        else $error("bank select not used");
    AST_ONE_CYC: assert property (take ##1 clk_en[*3]
            |-> phase_q == PH_Q4 ##1 phase_q == PH_Q1 || stopped_q)
        else $error("instruction did not finish in one cycle");
endmodule // sleep_sub_exec

// File: verification/tb_top.sv
// self-checking bench for the sleep and borrow-subtract executor
module tb_top
    import exec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic instr_ready;
    logic wake_watchdog = 1'b0;
    logic wake_other = 1'b0;
    logic watchdog_clear;
    logic postscaler_clear;
    logic osc_stop;
    logic irq;
    int mismatches = 0;
    int checks = 0;
    logic to_exp = 1'b1;
    logic pwrdn_exp = 1'b1;
    logic [4:0] flags_exp = 5'h00;
    // shadow of the file memory, which the bench clears before reset
    logic [7:0] shadow [4096] = '{default: 8'h00};

    // 25 MHz clock
    always #20 pclk = ~pclk;

    sleep_sub_exec #(.AW(12)) i_sleep_sub_exec (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_ready(instr_ready), .wake_watchdog(wake_watchdog),
        .wake_other(wake_other), .watchdog_clear(watchdog_clear),
        .postscaler_clear(postscaler_clear), .osc_stop(osc_stop),
        .irq(irq));

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // compare tasks, one per result width
    task automatic chk_word(input string what, input logic [31:0] e,
                            input logic [31:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_bit(input string what, input logic e, input logic g);
        chk_word(what, {31'h0, e}, {31'h0, g});
    endtask

    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] e);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        chk_word(what, e, rd);
    endtask

    // offer a word, wait for the Q1 take, then run through Q2..Q4
    task automatic exec_instr(input logic [15:0] w, input logic is_sleep);
        int n;
        n = 0;
        @(posedge pclk);
        instr_valid <= 1'b1;
        instr_word <= w;
        @(negedge pclk);
        while (instr_ready !== 1'b1 && n < 50) begin
            @(negedge pclk);
            n++;
        end
        @(posedge pclk);
        instr_valid <= 1'b0;
        repeat (3) @(posedge pclk);
        if (!is_sleep) begin
            @(negedge pclk);
            chk_bit("ready after one cycle", 1'b1, instr_ready);
        end
    endtask

    // one subtract with its expectation worked out beside it
    task automatic sub_case(input logic [7:0] w, input logic c,
        input logic [7:0] f, input logic a, input logic d, input logic [3:0] bs);
        logic [11:0] ea;
        logic [7:0] m;
        logic [8:0] full;
        logic [4:0] lo;
        ea = a ? {bs, f} : ((f < ACCESS_SPLIT) ? {ACCESS_LOW_BANK, f}
                                              : {ACCESS_HIGH_BANK, f});
        m = shadow[ea];
        full = {1'b0, w} - {1'b0, m} - {8'h00, ~c};
        lo = {1'b0, w[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c};
        flags_exp[C_POS] = ~full[8];
        flags_exp[DIGC_POS] = ~lo[4];
        flags_exp[Z_POS] = (full[7:0] == 8'h00);
        flags_exp[OVF_POS] = (w[7] != m[7]) && (full[7] != w[7]);
        flags_exp[N_POS] = full[7];
        wr(WORK_OFFS, {24'h0, w});
        wr(BANKSEL_OFFS, {28'h0, bs});
        wr(STATUS_OFFS, {31'h0, c});
        exec_instr({SUB_BORROW_TOP, d, a, f}, 1'b0);
        if (d) begin
            shadow[ea] = full[7:0];
        end
        rd_chk("working register", WORK_OFFS, {24'h0, d ? w : full[7:0]});
        rd_chk("status", STATUS_OFFS, {25'h0, to_exp, pwrdn_exp, flags_exp});
    endtask

    // sleep, check the stop state, then wake by the chosen source
    task automatic sleep_case(input logic by_wdt);
        int clr_n;
        logic [31:0] rd;
        logic err;
        clr_n = 0;
        wr(IRQ_STAT_OFFS, 32'h0000000F);
        wr(IRQ_MASK_OFFS, 32'h00000001);
        exec_instr(SLEEP_OPCODE, 1'b1);
        // both clears must pulse together for exactly one cycle
        repeat (4) begin
            @(negedge pclk);
            if (watchdog_clear === 1'b1 && postscaler_clear === 1'b1) begin
                clr_n++;
            end
        end
        chk_word("clear pulse cycles", 32'h1, 32'(clr_n));
        chk_bit("oscillator stop", 1'b1, osc_stop);
        chk_bit("instruction ready", 1'b0, instr_ready);
        chk_bit("sleep interrupt", 1'b1, irq);
        pwrdn_exp = 1'b0;
        to_exp = 1'b1;
        rd_chk("status", STATUS_OFFS, {25'h0, to_exp, pwrdn_exp, flags_exp});
        apb(1'b0, CORE_STATE_OFFS, 32'h0, rd, err);
        chk_bit("stopped", 1'b1, rd[2]);
        @(posedge pclk);
        wake_watchdog <= by_wdt;
        wake_other <= ~by_wdt;
        @(posedge pclk);
        wake_watchdog <= 1'b0;
        wake_other <= 1'b0;
        to_exp = by_wdt ? 1'b0 : 1'b1;
        @(negedge pclk);
        chk_bit("oscillator stop", 1'b0, osc_stop);
        rd_chk("status", STATUS_OFFS, {25'h0, to_exp, pwrdn_exp, flags_exp});
        rd_chk("irq status", IRQ_STAT_OFFS, by_wdt ? 32'h3 : 32'h5);
        // an unknown word must leave the working register alone
        wr(WORK_OFFS, 32'h000000A5);
        exec_instr(16'h0004, 1'b0);
        rd_chk("working register", WORK_OFFS, 32'h000000A5);
    endtask

    initial begin : main
        logic [31:0] rd;
        logic err;
        // the file memory has no reset; clear it so the shadow starts equal
        for (int i = 0; i < 4096; i++) begin
            i_sleep_sub_exec.u_ram.mem[i] = 8'h00;
        end
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("status", STATUS_OFFS, 32'h00000060);
        rd_chk("working register", WORK_OFFS, 32'h0);
        rd_chk("bank select", BANKSEL_OFFS, 32'h0);
        rd_chk("irq status", IRQ_STAT_OFFS, 32'h0);
        rd_chk("irq mask", IRQ_MASK_OFFS, 32'h0);
        rd_chk("core state", CORE_STATE_OFFS, 32'h0);
        wr(STATUS_OFFS, 32'h0);
        rd_chk("status read-only bits", STATUS_OFFS, 32'h00000060);
        apb(1'b0, 8'h18, 32'h0, rd, err);
        chk_bit("unmapped error", 1'b1, err);
        chk_word("unmapped read", 32'h0, rd);
        $display("test reset_map done");
        // chained cases so later reads see earlier file writes
        sub_case(8'h05, 1'b1, 8'h10, 1'b0, 1'b1, 4'h3);
        sub_case(8'h03, 1'b0, 8'h10, 1'b1, 1'b1, 4'h2);
        sub_case(8'h07, 1'b1, 8'h10, 1'b0, 1'b0, 4'h2);
        sub_case(8'h02, 1'b1, 8'h10, 1'b1, 1'b0, 4'h2);
        sub_case(8'h80, 1'b1, 8'h80, 1'b0, 1'b1, 4'h5);
        sub_case(8'h00, 1'b1, 8'h80, 1'b1, 1'b0, 4'hF);
        sub_case(8'h7F, 1'b0, 8'h10, 1'b1, 1'b0, 4'h0);
        sub_case(8'h10, 1'b1, 8'h10, 1'b0, 1'b0, 4'h9);
        $display("test subtract done");
        @(negedge pclk);
        chk_bit("masked interrupt", 1'b0, irq);
        wr(IRQ_MASK_OFFS, 32'h00000008);
        @(negedge pclk);
        chk_bit("unmasked interrupt", 1'b1, irq);
        wr(IRQ_STAT_OFFS, 32'h00000008);
        rd_chk("irq status", IRQ_STAT_OFFS, 32'h0);
        @(negedge pclk);
        chk_bit("cleared interrupt", 1'b0, irq);
        $display("test interrupt done");
        sleep_case(1'b1);
        sleep_case(1'b0);
        $display("test sleep done");
        @(posedge pclk);
        clk_en <= 1'b0;
        @(negedge pclk);
        chk_bit("frozen pready", 1'b0, pready);
        chk_bit("frozen instr ready", 1'b0, instr_ready);
        @(posedge pclk);
        clk_en <= 1'b1;
        $display("test freeze done");
        final_report();
    end

    // cuts a hang short well past the expected run length
    initial begin : watchdog
        repeat (20000) @(posedge pclk);
        mismatches++;
        $display("watchdog expired");
        final_report();
    end
endmodule // tb_top
